// ### src/autobaud_meter.sv
/*
 * measures the first start bit seen after arming; a carriage return begins with
 * a single low bit, so its low run is one bit time.
 * assumes rx is already synchronised to clock.
 */
`timescale 1ns/1ns
module autobaud_meter
	import chan_link_pkg::*;
#(
	parameter int W = CNT_W
)(
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         arm,
	input  wire logic         rx,
	output logic [W-1:0]      bit_cycles,
	output logic              done
);
	typedef enum logic [1:0] {
		AB_IDLE  = 2'b00,
		AB_WAIT  = 2'b01,
		AB_LOW   = 2'b10,
		AB_DONE  = 2'b11
	} ab_state_t;
	ab_state_t      state;
	logic [W-1:0]   run;

	// the counter must be at least two bits wide
	if (W < 2)
		$error("autobaud_meter: width too small");

	// wait for idle line, time the first low run, then hold the result
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			state      <= AB_DONE;
			run        <= '0;
			bit_cycles <= '0;
			done       <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			case (state)
				AB_IDLE: if (rx) state <= AB_WAIT;
				AB_WAIT:
				begin
					run <= '0;
					if (!rx) state <= AB_LOW;
				end
				AB_LOW:
				begin
					run <= run + 1'b1;
					if (rx)
					begin
						bit_cycles <= run + 1'b1;
						done       <= 1'b1;
						state      <= AB_DONE;
					end
				end
				default: ;
			endcase
			if (arm) state <= AB_IDLE;
		end
	end
endmodule

// ### src/chan_link_ctrl.sv
/*
 * channel-end modem-signal control, dial handshake, autobaud and link clock control,
 * with an apb register file and one level interrupt.
 * assumes pins reach it unsynchronised; far_lines and sw_disconnect come from
 * switching logic on the same clock.
 */
// Decided for this implementation: the address map and the APB slave port.
// Functional notes
// RULE1: async channel set to assert keeps carrier, dsr and cts always on.
// RULE2: switched assert-with-drop drops all three briefly on a switched disconnect.
// RULE3: pass setting relays far-end modem-control changes to this end's outputs.
// RULE4: synchronous channels always keep carrier, dsr and cts on.
// RULE5: with pass on a dial-up modem, the host runs the dial handshake.
// RULE6: device-run dialing flushes buffers, tracks connection, tears down on hangup; teardown_out pulses on switched channels only.
// RULE7: async dialing needs local or remote dial; only the local end runs it.
// RULE8: switched dial values run the handshake; originate variant allows outgoing calls.
// RULE9: autobaud times the first received character and uses that rate.
// RULE10: autobaud works whichever side runs the dial handshake.
// RULE11: restore command returns every option to its default at once.
// RULE12: first change to switched, sync or ddcmp starts that type at defaults.
// RULE13: sync link takes modem clock, rates up to 19.2 kbit/s.
// RULE14: async link generates its own clock at a fixed 9600 bit/s.
// RULE15: sync link reports measured clock period or a no-clock flag.
// RULE16: satellite delay lengthens the acknowledgement timeout.
// RULE17: nonzero switched channel signals override system setting; none uses system.
// RULE18: disconnect drop lasts a fixed configurable number of cycles.
`timescale 1ns/1ns
module chan_link_ctrl
	import chan_link_pkg::*;
#(
	parameter int DROP_CYCLES   = DROP_CYC,
	parameter int NOCLK_CYCLES  = NOCLK_CYC,
	parameter int LINK_HALF     = LINK_HALF_CYC,
	parameter int ACK_NORMAL    = ACK_NORMAL_CYC,
	parameter int ACK_SAT       = ACK_SAT_CYC
)(
	input  wire logic         clock,
	input  wire logic         rst,
	input  wire logic         psel,
	input  wire logic         penable,
	input  wire logic         pwrite,
	input  wire logic [7:0]   paddr,
	input  wire logic [31:0]  pwdata,
	output logic [31:0]       prdata,
	output logic              pready,
	output logic              pslverr,
	input  wire logic         dtr_pin,
	input  wire logic         rts_pin,
	input  wire logic         ring_pin,
	input  wire logic         rx_pin,
	input  wire logic [2:0]   far_lines,
	input  wire logic         sw_disconnect,
	input  wire logic         link_clk_pin,
	output logic              carrier_detect_out,
	output logic              dsr_out,
	output logic              cts_out,
	output logic [2:0]        local_lines,
	output logic              flush_out,
	output logic              teardown_out,
	output logic              link_clk_out,
	output logic              link_clk_oe,
	output logic [31:0]       ack_timeout,
	output logic [CNT_W-1:0]  chan_bit_cycles,
	output logic              irq
);
	if (DROP_CYCLES < 2 || NOCLK_CYCLES < 2 || LINK_HALF < 1 ||
		DROP_CYCLES >= (1 << CNT_W) || NOCLK_CYCLES >= (1 << CNT_W))
		$error("chan_link_ctrl: count parameter out of range");

	chan_type_t          cur_type;
	sig_mode_t           cur_sig;
	logic                sys_pass, link_async, sat, autobaud;
	logic [4:0]          type_seen;
	logic [2:0]          dtr_m, rts_m, ring_m, rx_m, lck_m;
	logic                dtr_s, rts_s, ring_s, rx_s, lck_s, lck_d;
	logic [2:0]          line_out;
	logic [CNT_W-1:0]    drop_cnt, link_cnt, link_period, div_cnt;
	logic                no_clock;
	dial_state_t         dial_state;
	logic [INT_W-1:0]    int_stat, int_mask, rd_clear;
	logic [CNT_W-1:0]    baud_cycles;
	logic                baud_done;

	// register decode
	wire setup    = psel && !penable;
	wire access   = psel && penable;
	wire mapped   = paddr == REG_CTRL || paddr == REG_STATUS || paddr == REG_LINK ||
		paddr == REG_BAUD || paddr == REG_INT_STAT || paddr == REG_INT_MASK;
	wire wr_ctrl  = access && pwrite && paddr == REG_CTRL;
	wire wr_mask  = access && pwrite && paddr == REG_INT_MASK;
	wire restore  = wr_ctrl && pwdata[CTRL_RESTORE];
	wire chan_type_t new_type = chan_type_t'(pwdata[CTRL_TYPE_LSB +: 3]);
	wire first_use = new_type <= TYPE_UNUSED && new_type != cur_type && !type_seen[new_type];

	// default signals setting for a channel type
	function automatic sig_mode_t type_default(input chan_type_t t);
		type_default = (t == TYPE_SWITCHED) ? DEF_SIG_SW : DEF_SIG_ASYNC;
	endfunction

	// option registers
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			cur_type   <= DEF_TYPE;
			cur_sig    <= DEF_SIG_ASYNC;
			sys_pass   <= DEF_SYS_PASS;
			link_async <= DEF_LINK_ASYNC;
			sat        <= DEF_SAT;
			autobaud   <= DEF_AUTOBAUD;
			type_seen  <= 5'h01;
		end
		else if (restore)
		begin
			cur_type   <= DEF_TYPE; // see RULE11
			cur_sig    <= DEF_SIG_ASYNC;
			sys_pass   <= DEF_SYS_PASS;
			link_async <= DEF_LINK_ASYNC;
			sat        <= DEF_SAT;
			autobaud   <= DEF_AUTOBAUD;
			type_seen  <= 5'h01;
		end
		else if (wr_ctrl)
		begin
			cur_type   <= new_type;
			sys_pass   <= pwdata[CTRL_SYS_PASS];
			link_async <= pwdata[CTRL_LINK_ASYNC];
			sat        <= pwdata[CTRL_SAT];
			if (new_type <= TYPE_UNUSED)
				type_seen[new_type] <= 1'b1;
			if (first_use)
			begin
				cur_sig  <= type_default(new_type); // see RULE12
				autobaud <= DEF_AUTOBAUD;
			end
			else
			begin
				cur_sig  <= sig_mode_t'(pwdata[CTRL_SIG_LSB +: 3]);
				autobaud <= pwdata[CTRL_AUTOBAUD];
			end
		end
	end

	// pin synchronisers, three flops each
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			{dtr_m, rts_m, ring_m, rx_m, lck_m} <= '0;
			lck_d <= 1'b0;
		end
		else
		begin
			dtr_m  <= {dtr_m[1:0], dtr_pin};
			rts_m  <= {rts_m[1:0], rts_pin};
			ring_m <= {ring_m[1:0], ring_pin};
			rx_m   <= {rx_m[1:0], rx_pin};
			lck_m  <= {lck_m[1:0], link_clk_pin};
			lck_d  <= lck_s;
		end
	end
	assign dtr_s  = dtr_m[2];
	assign rts_s  = rts_m[2];
	assign ring_s = ring_m[2];
	assign rx_s   = rx_m[2];
	assign lck_s  = lck_m[2];

	// effective signals setting and who runs the dial handshake
	wire is_sw      = cur_type == TYPE_SWITCHED;
	wire is_async   = cur_type == TYPE_ASYNC;
	wire sig_mode_t eff_sig = (is_sw && cur_sig == SIG_NONE) ? // see RULE17
		(sys_pass ? SIG_PASS : SIG_ASSERT) : cur_sig;
	wire dial_run   = (is_async && eff_sig == SIG_LDIAL) || // see RULE7
		(is_sw && (eff_sig == SIG_DIAL || eff_sig == SIG_DIAL_ORIG)); // see RULE8
	wire orig_ok    = is_sw && eff_sig == SIG_DIAL_ORIG;
	wire drop_now   = is_sw && eff_sig == SIG_ASSERT_DROP &&
		(sw_disconnect || drop_cnt != '0);

	// dial handshake state
	dial_state_t next_dial;
	always_comb
	begin
		next_dial = dial_state;
		case (dial_state)
			DIAL_IDLE:
				if (ring_s || (orig_ok && rts_s)) // see RULE8
					next_dial = DIAL_ANSWER;
			DIAL_ANSWER:
				if (dtr_s)
					next_dial = DIAL_ONLINE;
				else if (!ring_s && !(orig_ok && rts_s))
					next_dial = DIAL_IDLE;
			DIAL_ONLINE:
				if (!dtr_s)
					next_dial = DIAL_HANGUP; // see RULE6
			default:
				next_dial = DIAL_IDLE;
		endcase
		if (!dial_run)
			next_dial = DIAL_IDLE;
	end

	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			dial_state <= DIAL_IDLE;
		else
			dial_state <= next_dial;
	end

	// drop timer for switched disconnect
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			drop_cnt <= '0;
		else if (sw_disconnect && is_sw && eff_sig == SIG_ASSERT_DROP)
			drop_cnt <= CNT_W'(DROP_CYCLES - 1); // see RULE18
		else if (drop_cnt != '0)
			drop_cnt <= drop_cnt - 1'b1;
	end

	// modem-control output selection
	logic [2:0] next_line;
	always_comb
	begin
		case (cur_type)
			TYPE_SYNC, TYPE_DDCMP: next_line = LINES_ON; // see RULE4
			TYPE_ASYNC, TYPE_SWITCHED:
				case (eff_sig)
					SIG_PASS, SIG_RDIAL: next_line = far_lines; // see RULE3
					SIG_ASSERT_DROP: next_line = drop_now ? LINES_OFF : LINES_ON; // see RULE2
					SIG_LDIAL, SIG_DIAL, SIG_DIAL_ORIG:
						next_line = !dial_run ? LINES_ON :
							dial_state == DIAL_ONLINE ? LINES_ON :
							dial_state == DIAL_ANSWER ? LINES_DSR : LINES_OFF;
					default: next_line = LINES_ON; // see RULE1
				endcase
			default: next_line = LINES_OFF;
		endcase
	end

	// registered line outputs and hangup pulses
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			line_out     <= LINES_OFF;
			local_lines  <= LINES_OFF;
			flush_out    <= 1'b0;
			teardown_out <= 1'b0;
		end
		else
		begin
			line_out     <= next_line;
			local_lines  <= {ring_s, rts_s, dtr_s}; // relayed so the host can dial, see RULE5
			flush_out    <= next_dial == DIAL_HANGUP; // see RULE6
			teardown_out <= next_dial == DIAL_HANGUP && is_sw;
		end
	end
	assign {carrier_detect_out, dsr_out, cts_out} = line_out;

	// link clock: measured in sync mode, generated in async mode
	wire lck_rise = lck_s && !lck_d;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			link_cnt    <= '0;
			link_period <= '0;
			no_clock    <= 1'b1;
			div_cnt     <= '0;
			link_clk_out <= 1'b0;
		end
		else if (link_async)
		begin
			no_clock <= 1'b0;
			link_cnt <= '0;
			div_cnt  <= (div_cnt == CNT_W'(LINK_HALF - 1)) ? '0 : div_cnt + 1'b1;
			if (div_cnt == CNT_W'(LINK_HALF - 1))
				link_clk_out <= !link_clk_out; // see RULE14
		end
		else
		begin
			link_clk_out <= 1'b0;
			div_cnt      <= '0;
			if (lck_rise)
			begin
				link_period <= link_cnt + 1'b1; // see RULE13
				link_cnt    <= '0;
				no_clock    <= 1'b0;
			end
			else if (link_cnt == CNT_W'(NOCLK_CYCLES - 1))
				no_clock    <= 1'b1; // see RULE15
			else
				link_cnt    <= link_cnt + 1'b1;
		end
	end
	assign link_clk_oe = link_async;
	wire too_fast = !no_clock && link_period < CNT_W'(LINK_MIN_CYC);

	// acknowledgement timeout follows the delay setting
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ack_timeout <= 32'(ACK_NORMAL);
		else
			ack_timeout <= sat ? 32'(ACK_SAT) : 32'(ACK_NORMAL); // see RULE16
	end

	// autobaud re-arms on enable and on a device-run hangup; restore turns autobaud off
	logic ab_en_d;
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			ab_en_d <= 1'b0;
		else
			ab_en_d <= autobaud;
	end
	wire ab_arm = (autobaud && !ab_en_d) || (autobaud && flush_out); // see RULE10
	autobaud_meter #(.W(CNT_W)) u_baud (
		.clock      (clock),
		.rst        (rst),
		.arm        (ab_arm),
		.rx         (rx_s),
		.bit_cycles (baud_cycles),
		.done       (baud_done)
	);
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			chan_bit_cycles <= CNT_W'(FIXED_BIT_CYC);
		else
			chan_bit_cycles <= (autobaud && baud_cycles != '0) ? // see RULE9
				baud_cycles : CNT_W'(FIXED_BIT_CYC);
	end

	// interrupt status: set wins, a read clears only what it returned
	logic no_clock_d;
	wire [INT_W-1:0] events = {sw_disconnect && drop_now, baud_done,
		no_clock && !no_clock_d, next_dial == DIAL_HANGUP && dial_state != DIAL_HANGUP};
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			int_stat   <= '0;
			int_mask   <= '0;
			no_clock_d <= 1'b1;
		end
		else
		begin
			no_clock_d <= no_clock;
			int_stat   <= (int_stat & ~rd_clear) | events;
			if (wr_mask)
				int_mask <= pwdata[INT_W-1:0];
		end
	end
	assign irq = |(int_stat & int_mask);

	// read data captured in the setup phase, zero wait states
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			prdata   <= '0;
			rd_clear <= '0;
		end
		else if (setup && !pwrite)
		begin
			rd_clear <= '0;
			case (paddr)
				REG_CTRL: prdata <= 32'({autobaud, sat, link_async, sys_pass,
					1'b0, cur_sig, 1'b0, cur_type});
				REG_STATUS: prdata <= 32'({too_fast, no_clock, dial_state, line_out});
				REG_LINK: prdata <= 32'(link_period);
				REG_BAUD: prdata <= 32'(baud_cycles);
				REG_INT_STAT:
				begin
					prdata   <= 32'(int_stat);
					rd_clear <= int_stat;
				end
				REG_INT_MASK: prdata <= 32'(int_mask);
				default: prdata <= '0;
			endcase
		end
		else if (access)
			rd_clear <= '0;
	end
	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// checks
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sync_lines_on_a: assert property (cur_type == TYPE_SYNC |=> line_out == LINES_ON) // see RULE4
		else $error("sync channel lines not all on");
	assert_lines_a: assert property (is_async && eff_sig == SIG_ASSERT |=> line_out == LINES_ON) // see RULE1
		else $error("assert setting lines not on");
	drop_lines_a: assert property (is_sw && eff_sig == SIG_ASSERT_DROP && sw_disconnect // see RULE2
		##1 (is_sw && eff_sig == SIG_ASSERT_DROP) |=> line_out == LINES_OFF)
		else $error("lines not dropped on disconnect");
	pass_relay_a: assert property (is_async && eff_sig == SIG_PASS |=> line_out == $past(far_lines)) // see RULE3
		else $error("pass setting did not relay");
	hangup_pulse_a: assert property (dial_run && dial_state == DIAL_ONLINE && !dtr_s // see RULE6
		|=> flush_out && dial_state == DIAL_HANGUP)
		else $error("hangup not flushed");
	rdial_idle_a: assert property (is_async && eff_sig == SIG_RDIAL |=> dial_state == DIAL_IDLE) // see RULE7
		else $error("remote dial ran the handshake");
	sw_none_sys_a: assert property (is_sw && cur_sig == SIG_NONE && !sys_pass // see RULE17
		|=> line_out == LINES_ON)
		else $error("system switched setting ignored");
	ack_sat_a: assert property (sat |=> ack_timeout == 32'(ACK_SAT)) // see RULE16
		else $error("satellite timeout not applied");
	restore_def_a: assert property (restore |=> cur_type == DEF_TYPE && cur_sig == DEF_SIG_ASYNC // see RULE11
		&& !sat && !link_async)
		else $error("restore left options changed");
	event_set_a: assert property (events[INT_NOCLK] |=> int_stat[INT_NOCLK]) // see RULE15
		else $error("no-clock event lost");
	online_c: cover property (dial_state == DIAL_ONLINE);
	baud_c: cover property (baud_done);
	noclk_c: cover property ($rose(no_clock));
endmodule

// ### src/chan_link_pkg.sv
/*
 * constants, field layout and types for the channel modem-signal and link control.
 * assumes a single 125 MHz system clock.
 */
package chan_link_pkg;
	// timing figures in their own units
	localparam int CLK_HZ        = 125_000_000;
	localparam int ASYNC_LINK_BPS = 9600;
	localparam int SYNC_MAX_BPS  = 19200;
	localparam int FIXED_CHAN_BPS = 1200;
	localparam int NOCLK_MS      = 10;
	localparam int DROP_MS       = 100;
	localparam int ACK_NORMAL_MS = 1000;
	localparam int ACK_SAT_MS    = 3000;
	// derived cycle counts: longest times round down, least times round up
	localparam int LINK_HALF_CYC = CLK_HZ / (2 * ASYNC_LINK_BPS);
	localparam int LINK_MIN_CYC  = (CLK_HZ + SYNC_MAX_BPS - 1) / SYNC_MAX_BPS;
	localparam int NOCLK_CYC     = (CLK_HZ / 1000) * NOCLK_MS;
	localparam int DROP_CYC      = (CLK_HZ / 1000) * DROP_MS;
	localparam int ACK_NORMAL_CYC = (CLK_HZ / 1000) * ACK_NORMAL_MS;
	localparam int ACK_SAT_CYC   = (CLK_HZ / 1000) * ACK_SAT_MS;
	localparam int FIXED_BIT_CYC = CLK_HZ / FIXED_CHAN_BPS;
	localparam int CNT_W         = 24;
	// register byte offsets
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_LINK     = 8'h08;
	localparam logic [7:0] REG_BAUD     = 8'h0c;
	localparam logic [7:0] REG_INT_STAT = 8'h10;
	localparam logic [7:0] REG_INT_MASK = 8'h14;
	// control field positions
	localparam int CTRL_TYPE_LSB  = 0;
	localparam int CTRL_SIG_LSB   = 4;
	localparam int CTRL_SYS_PASS  = 8;
	localparam int CTRL_LINK_ASYNC = 9;
	localparam int CTRL_SAT       = 10;
	localparam int CTRL_AUTOBAUD  = 11;
	localparam int CTRL_RESTORE   = 31;
	// interrupt bits
	localparam int INT_HANGUP = 0;
	localparam int INT_NOCLK  = 1;
	localparam int INT_BAUD   = 2;
	localparam int INT_DROP   = 3;
	localparam int INT_W      = 4;
	typedef enum logic [2:0] {
		TYPE_ASYNC    = 3'b000,
		TYPE_SWITCHED = 3'b001,
		TYPE_SYNC     = 3'b010,
		TYPE_DDCMP    = 3'b011,
		TYPE_UNUSED   = 3'b100
	} chan_type_t;
	typedef enum logic [2:0] {
		SIG_NONE      = 3'b000,
		SIG_ASSERT    = 3'b001,
		SIG_ASSERT_DROP = 3'b010,
		SIG_PASS      = 3'b011,
		SIG_LDIAL     = 3'b100,
		SIG_RDIAL     = 3'b101,
		SIG_DIAL      = 3'b110,
		SIG_DIAL_ORIG = 3'b111
	} sig_mode_t;
	typedef enum logic [1:0] {
		DIAL_IDLE   = 2'b00,
		DIAL_ANSWER = 2'b01,
		DIAL_ONLINE = 2'b10,
		DIAL_HANGUP = 2'b11
	} dial_state_t;
	// option defaults
	localparam chan_type_t DEF_TYPE   = TYPE_ASYNC;
	localparam sig_mode_t  DEF_SIG_ASYNC = SIG_ASSERT;
	localparam sig_mode_t  DEF_SIG_SW = SIG_NONE;
	localparam logic       DEF_SYS_PASS = 1'b0;
	localparam logic       DEF_LINK_ASYNC = 1'b0;
	localparam logic       DEF_SAT    = 1'b0;
	localparam logic       DEF_AUTOBAUD = 1'b0;
	localparam logic [2:0] LINES_ON   = 3'b111;
	localparam logic [2:0] LINES_OFF  = 3'b000;
	localparam logic [2:0] LINES_DSR  = 3'b010;
endpackage

// ### verif/chan_modem_model.sv
/*
 * channel-side terminal or modem: dial pins, receive data and the link clock.
 * assumes the bench steers it with levels and a strobe, all set after a clock edge.
 */
`timescale 1ns/1ns
module chan_modem_model (
	input  wire logic        clock,
	input  wire logic        ring_on,
	input  wire logic        carrier_on,
	input  wire logic        orig_on,
	input  wire logic        send_cr,
	input  wire logic [7:0]  bit_cyc,
	input  wire logic        link_run,
	output logic             dtr_pin,
	output logic             rts_pin,
	output logic             ring_pin,
	output logic             rx_pin,
	output logic             link_clk_pin
);
	logic [9:0] frame;
	int         k;

	// dial pins follow the scenario; in pass mode the host dials via relayed lines
	assign dtr_pin  = carrier_on;
	assign rts_pin  = orig_on;
	assign ring_pin = ring_on;

	initial rx_pin = 1'b1;
	initial link_clk_pin = 1'b0;

	// carriage return, start bit first, each bit held bit_cyc clocks; idle mark
	always @(posedge send_cr)
	begin
		frame = {1'b1, 8'h0d, 1'b0};
		for (k = 0; k < 10; k++)
		begin
			rx_pin <= frame[k];
			repeat (bit_cyc) @(posedge clock);
		end
	end

	// modem link clock, 64 ns period, stands low outside a run
	always
	begin
		wait (link_run);
		#3 link_clk_pin = 1'b1;
		#32 link_clk_pin = 1'b0;
		#29;
	end
endmodule

// ### verif/tb_chan_link_ctrl.sv
/*
 * self-checking bench: apb tasks note expected results, a monitor compares them.
 * assumes shortened drop, no-clock, link and ack counts set at the instance.
 */
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
	$display("CHECK FAILED %0t result differs", $time); end end
module tb_chan_link_ctrl
	import chan_link_pkg::*;
;
	typedef struct {
		logic [32:0] exp;
		logic [32:0] mask;
	} note_t;
	note_t              notes[$];
	int                 mismatches = 0;
	int                 comparisons = 0;
	int                 seed;
	logic               clock = 1'b0;
	logic               rst = 1'b1;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [7:0]         paddr = 8'h0;
	logic [31:0]        pwdata = 32'h0;
	logic [2:0]         far_lines = 3'h0;
	logic               sw_disconnect = 1'b0;
	logic               ring_on = 1'b0;
	logic               carrier_on = 1'b0;
	logic               orig_on = 1'b0;
	logic               send_cr = 1'b0;
	logic               link_run = 1'b0;
	logic               tok = 1'b0;
	logic               tok_seen = 1'b0;
	logic [3:0]         flush_cnt = 4'h0;
	logic [3:0]         tear_cnt = 4'h0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               dtr_pin;
	logic               rts_pin;
	logic               ring_pin;
	logic               rx_pin;
	logic               link_clk_pin;
	logic               carrier_detect_out;
	logic               dsr_out;
	logic               cts_out;
	logic               flush_out;
	logic               teardown_out;
	logic               link_clk_oe;
	logic [31:0]        ack_timeout;
	logic               irq;
	logic [32:0]        obs;
	logic [2:0]         local_lines;
	logic               link_clk_out;
	logic [23:0]        chan_bit_cycles;
	logic [7:0]         bit_cyc = 8'h18;

	always #4 clock = ~clock;

	chan_modem_model modem (
		.clock        (clock),
		.ring_on      (ring_on),
		.carrier_on   (carrier_on),
		.orig_on      (orig_on),
		.send_cr      (send_cr),
		.bit_cyc      (bit_cyc),
		.link_run     (link_run),
		.dtr_pin      (dtr_pin),
		.rts_pin      (rts_pin),
		.ring_pin     (ring_pin),
		.rx_pin       (rx_pin),
		.link_clk_pin (link_clk_pin)
	);

	chan_link_ctrl #(.DROP_CYCLES(8), .NOCLK_CYCLES(64), .LINK_HALF(4),
		.ACK_NORMAL(100), .ACK_SAT(300)) uut (
		.clock (clock), .rst (rst), .psel (psel), .penable (penable),
		.pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .prdata (prdata),
		.pready (pready), .pslverr (pslverr), .dtr_pin (dtr_pin),
		.rts_pin (rts_pin), .ring_pin (ring_pin), .rx_pin (rx_pin),
		.far_lines (far_lines), .sw_disconnect (sw_disconnect),
		.link_clk_pin (link_clk_pin), .carrier_detect_out (carrier_detect_out),
		.dsr_out (dsr_out), .cts_out (cts_out), .local_lines (local_lines),
		.flush_out (flush_out), .teardown_out (teardown_out), .link_clk_out (link_clk_out),
		.link_clk_oe (link_clk_oe), .ack_timeout (ack_timeout),
		.chan_bit_cycles (chan_bit_cycles), .irq (irq)
	);

	// observed word: [32:18] bit period, [17] link clock, [16:14] relayed pins,
	// [13] satellite ack, [12] link drive, flush, teardown, irq, lines
	assign obs = {chan_bit_cycles[14:0], link_clk_out, local_lines, ack_timeout === 32'd300,
		link_clk_oe, flush_cnt, tear_cnt, irq, carrier_detect_out, dsr_out, cts_out};

	task automatic close_out();
		if (mismatches == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic take(input logic [32:0] got);
		note_t n;
		n = notes.pop_front();
		`CHK(got & n.mask, n.exp & n.mask)
	endtask

	// pulse counters, then the comparing side of the notes queue
	always @(posedge clock)
	begin
		if (flush_out === 1'b1)
			flush_cnt <= flush_cnt + 4'h1;
		if (teardown_out === 1'b1)
			tear_cnt <= tear_cnt + 4'h1;
		tok_seen <= tok;
		if (psel && penable && pready === 1'b1 && !pwrite)
			take({pslverr, prdata});
		else if (tok !== tok_seen)
			take(obs);
	end

	task automatic wt(input int n);
		repeat (n) @(posedge clock);
	endtask

	// one apb transfer; an idle edge first keeps drivers single per step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 16);
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			mismatches++;
			close_out();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
		notes.push_back('{e, m | 33'h1_0000_0000});
		apb(1'b0, a, 32'h0);
	endtask

	// note an expected port word, sampled at the next edge
	task automatic pk(input logic [32:0] e, input logic [32:0] m);
		notes.push_back('{e, m});
		tok <= ~tok;
		@(posedge clock);
	endtask

	// answer by ring or by outgoing request, go online, then lose carrier
	task automatic dial(input logic o, input logic [3:0] f, input logic [3:0] t);
		wt(8);
		pk(33'h0, 33'h7);
		if (o)
			orig_on <= 1'b1;
		else
			ring_on <= 1'b1;
		wt(8);
		pk(o ? 33'h0_8002 : 33'h1_0002, 33'h1_c007);
		carrier_on <= 1'b1;
		wt(8);
		ring_on <= 1'b0;
		orig_on <= 1'b0;
		rd(REG_STATUS, 33'h17, 33'h1f);
		carrier_on <= 1'b0;
		wt(8);
		pk(33'({f, t, 4'h8}), 33'hfff);
	endtask

	initial
	begin
		repeat (20000) @(posedge clock);
		mismatches++;
		close_out();
	end

	initial
	begin
		seed = 32'h9b26;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		rd(REG_CTRL, 33'h10, 33'hffff_ffff);
		rd(REG_STATUS, 33'h27, 33'h27);
		rd(REG_INT_MASK, 33'h0, 33'hffff_ffff);
		rd(8'h18, 33'h1_0000_0000, 33'hffff_ffff);
		pk(33'(FIXED_BIT_CYC & 16'h7fff) << 18, 33'h1_fffc_3000);
		// async channel, each signals value but none and local dial, random far lines
		for (int v = 1; v < 8; v++)
		begin
			if (v == 4)
				continue;
			far_lines <= 3'($random(seed));
			wr(REG_CTRL, 32'(v << 4));
			wt(3);
			pk((v == 3 || v == 5) ? 33'(far_lines) : 33'h7, 33'h7);
		end
		// first move to sync loads defaults; sync ignores far lines
		wr(REG_CTRL, 32'h0000_0032);
		rd(REG_CTRL, 33'h12, 33'h7f);
		wr(REG_CTRL, 32'h0000_0032);
		far_lines <= 3'h5;
		wt(3);
		pk(33'h7, 33'h7);
		// switched none follows the system setting
		wr(REG_CTRL, 32'h0000_0021);
		rd(REG_CTRL, 33'h1, 33'h7f);
		pk(33'h7, 33'h7);
		wr(REG_CTRL, 32'h0000_0101);
		wt(3);
		pk(33'h5, 33'h7);
		wr(REG_CTRL, 32'h0000_0121);
		// one disconnect pulse: lines off for exactly the drop count
		@(posedge clock);
		sw_disconnect <= 1'b1;
		pk(33'h7, 33'h7);
		sw_disconnect <= 1'b0;
		pk(33'h0, 33'h7);
		wt(6);
		pk(33'h0, 33'h7);
		pk(33'h7, 33'h7);
		rd(REG_INT_STAT, 33'h8, 33'h9);
		rd(REG_INT_STAT, 33'h0, 33'h9);
		// local dial on async, then mask and clear the hangup interrupt
		wr(REG_INT_MASK, 32'h0000_0001);
		wr(REG_CTRL, 32'h0000_0040);
		dial(1'b0, 4'h1, 4'h0);
		wr(REG_INT_MASK, 32'h0000_0000);
		pk(33'h0, 33'h8);
		wr(REG_INT_MASK, 32'h0000_0001);
		pk(33'h8, 33'h8);
		rd(REG_INT_STAT, 33'h1, 33'h1);
		pk(33'h0, 33'h8);
		// switched dial with originate: tears the connection down too
		wr(REG_CTRL, 32'h0000_0071);
		dial(1'b1, 4'h2, 4'h1);
		// autobaud with the host owning the handshake, random bit time 16 to 23 clocks
		bit_cyc <= 8'h10 + 8'($random(seed) & 7);
		wr(REG_CTRL, 32'h0000_0830);
		send_cr <= 1'b1;
		wt(300);
		send_cr <= 1'b0;
		rd(REG_BAUD, 33'(bit_cyc), 33'hffff_ffff);
		rd(REG_INT_STAT, 33'h4, 33'h4);
		pk(33'(bit_cyc) << 18, 33'h1_fffc_0000);
		// modem link clock measured, then lost; async link and satellite delay
		link_run <= 1'b1;
		wt(40);
		rd(REG_LINK, 33'h8, 33'hffff_ffff);
		rd(REG_STATUS, 33'h40, 33'h60);
		link_run <= 1'b0;
		wt(80);
		rd(REG_STATUS, 33'h20, 33'h20);
		wr(REG_CTRL, 32'h0000_0610);
		wt(2);
		pk(33'h3000, 33'h2_3000);
		wt(1);
		pk(33'h2_0000, 33'h2_0000);
		// restore everything, then the first switch loads defaults again
		wr(REG_CTRL, 32'h8000_0000);
		rd(REG_CTRL, 33'h10, 33'hffff_ffff);
		wt(2);
		pk(33'h7, 33'h3007);
		wr(REG_CTRL, 32'h0000_0021);
		rd(REG_CTRL, 33'h1, 33'h7f);
		wt(4);
		`CHK(notes.size(), 0)
		close_out();
	end
endmodule
